/* File: rtl/rchop_ctrl.sv */
`timescale 1ns/10ps
// Operation
// - hop disabled: trim output equals configured trim, no offset
// - hop enabled: trim varies around base per selected pattern
// - pattern 0 offsets +0,+1,+2,+3,+0,-1,-2,-3 repeating
// - pattern 1 offsets +0,+2,+4,+6,+0,-2,-4,-6 repeating
// - advance one step every 10 us, wrapping last to first
// - trim is 7 bits, 00h lowest, 7Fh highest frequency
module rchop_ctrl (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic      [6:0] osc_trim_value,
    output logic      [3:0] timer3_rate_select
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]                   auxctl_q;     // auxiliary_control_3
    logic [6:0]                   trim_cfg_q;
    logic [7:0]                   rdata_q;
    logic [7:0]                   rdata_d;
    logic [rchop_pkg::STEP_W-1:0] step_q;
    logic [rchop_pkg::STEP_W-1:0] step_d;
    logic [6:0]                   trim_q;
    logic [6:0]                   trim_d;

    wire        wr_auxctl;
    wire        wr_trim;
    wire        hop_enable;
    wire        hop_pattern_select;
    wire        step_tick;
    wire [2:0]  mag;
    wire        neg;
    wire [3:0]  offset_mag;
    wire [7:0]  base_ext;
    wire [7:0]  up_sum;
    wire [7:0]  hop_trim;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign wr_auxctl          = reg_wr && (reg_addr == rchop_pkg::AUX_CTRL3_ADDR);
    assign wr_trim            = reg_wr && (reg_addr == rchop_pkg::TRIM_CFG_ADDR);
    assign hop_enable         = auxctl_q[rchop_pkg::HOP_EN_BIT];
    assign hop_pattern_select = auxctl_q[rchop_pkg::HOP_SEL_BIT];
    assign timer3_rate_select = auxctl_q[rchop_pkg::RATE_MSB:rchop_pkg::RATE_LSB];

    // read mux, unmapped and reserved bits read zero
    assign rdata_d = !reg_rd ? 8'h00 :
                     (reg_addr == rchop_pkg::AUX_CTRL3_ADDR) ? auxctl_q :
                     (reg_addr == rchop_pkg::TRIM_CFG_ADDR) ? {1'b0, trim_cfg_q} :
                     8'h00;

    // register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            auxctl_q   <= rchop_pkg::AUX_CTRL3_RESET;
            trim_cfg_q <= rchop_pkg::TRIM_RESET;
            rdata_q    <= 8'h00;
        end else begin
            if (wr_auxctl) begin
                auxctl_q <= reg_wdata & rchop_pkg::AUX_CTRL3_WR_MASK;  // bit 7 reserved
            end
            if (wr_trim) begin
                trim_cfg_q <= reg_wdata[rchop_pkg::TRIM_MSB:0];
            end
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // hop timebase
    // ------------------------------------------------------------------
    rchop_step_timer #(
        .STEP_CYCLES (rchop_pkg::STEP_CYCLES)
    ) u_timer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .run   (hop_enable),
        .tick  (step_tick)
    );

    assign step_d = !hop_enable ? '0 :
                    (step_tick ? step_q + 1'b1 : step_q);  // wraps 7 to 0

    // ------------------------------------------------------------------
    // offset pattern: steps 0..3 rise, 4..7 fall, magnitude = low bits, doubled in pattern 1
    // ------------------------------------------------------------------
    // pattern table
    assign mag        = {1'b0, step_q[rchop_pkg::STEP_DIR_BIT-1:0]};
    assign neg        = step_q[rchop_pkg::STEP_DIR_BIT];
    assign offset_mag = hop_pattern_select ? {mag, 1'b0} : {1'b0, mag};

    assign base_ext = {1'b0, trim_cfg_q};
    assign up_sum   = base_ext + {4'h0, offset_mag};
    assign hop_trim = !neg ? ((up_sum > rchop_pkg::TRIM_MAX) ? rchop_pkg::TRIM_MAX : up_sum) :
                      ((base_ext < {4'h0, offset_mag}) ? rchop_pkg::TRIM_MIN :
                       base_ext - {4'h0, offset_mag});

    assign trim_d = hop_enable ? hop_trim[6:0] : trim_cfg_q;

    // trim output register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= '0;
            trim_q <= rchop_pkg::TRIM_RESET;
        end else begin
            step_q <= step_d;
            trim_q <= trim_d;
        end
    end

    assign osc_trim_value = trim_q;

endmodule : rchop_ctrl

/* File: rtl/rchop_pkg.sv */
package rchop_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] AUX_CTRL3_ADDR  = 8'hef;   // auxiliary_control_3
    localparam logic [7:0] TRIM_CFG_ADDR   = 8'hf6;   // osc_trim_config
    localparam logic [7:0] AUX_CTRL3_RESET = 8'h00;
    localparam logic [7:0] AUX_CTRL3_WR_MASK = 8'h7f; // bit 7 reserved, always stores zero
    localparam logic [6:0] TRIM_RESET      = 7'h40;   // mid-range trim after reset
    localparam int         HOP_EN_BIT      = 1;
    localparam int         HOP_SEL_BIT     = 0;
    localparam int         RATE_LSB        = 3;
    localparam int         RATE_MSB        = 6;
    localparam int         TRIM_MSB        = 6;

    // ------------------------------------------------------------------
    // trim range and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] TRIM_MAX        = 8'h7f;
    localparam logic [7:0] TRIM_MIN        = 8'h00;
    localparam int         STEP_NS         = 10000;   // 10 us hop step
    localparam int         CLK_PERIOD_NS   = 5;       // mclk at 200 MHz
    localparam int         STEP_CYCLES     = STEP_NS / CLK_PERIOD_NS;
    localparam int         STEP_CNT_W      = 12;
    localparam int         STEP_W          = 3;       // eight steps per pattern
    localparam int         STEP_DIR_BIT    = 2;       // step bit that selects the falling half

endpackage : rchop_pkg

/* File: rtl/rchop_step_timer.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// step timebase: one-cycle tick every STEP_CYCLES while enabled
// ----------------------------------------------------------------------
module rchop_step_timer #(
    parameter int STEP_CYCLES = rchop_pkg::STEP_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);

    localparam logic [rchop_pkg::STEP_CNT_W-1:0] LAST =
        rchop_pkg::STEP_CNT_W'(STEP_CYCLES - 1);

    logic [rchop_pkg::STEP_CNT_W-1:0] cnt_q;
    logic [rchop_pkg::STEP_CNT_W-1:0] cnt_d;
    wire                              at_end;

    assign at_end = (cnt_q == LAST);
    assign cnt_d  = !run ? '0 : (at_end ? '0 : cnt_q + 1'b1);

    // counter restarts whenever hopping stops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = run && at_end;

endmodule : rchop_step_timer

/* File: tb/rchop_ctrl_assertions.sv */
`timescale 1ns/10ps
module rchop_ctrl_chk (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] osc_trim_value,
    input wire logic [3:0] timer3_rate_select
);
    logic [7:0] aux_q;
    logic [6:0] base_q;
    wire        hop_on = aux_q[1];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // shadow copies of the two registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aux_q  <= 8'h00;
            base_q <= 7'h40;
        end else if (reg_wr) begin
            if (reg_addr == 8'hef) aux_q <= reg_wdata;
            if (reg_addr == 8'hf6) base_q <= reg_wdata[6:0];
        end
    end
    hop_off_a: assert property (!hop_on && !reg_wr |=> osc_trim_value == base_q)
        else $error("trim differs from base with hop off");
    hop_start_a: assert property ($rose(hop_on) |-> osc_trim_value == base_q ##1
        $stable(osc_trim_value)[*8]) else $error("hop start step wrong");
    hop_sat_a: assert property (hop_on && base_q < 7'h07 && !reg_wr |=>
        osc_trim_value < 7'h0e) else $error("trim wrapped below zero");
    trim_read_a: assert property (reg_rd && reg_addr == 8'hf6 |=>
        reg_rdata[6:0] == base_q) else $error("trim readback wrong");
    aux_read_a: assert property (reg_rd && reg_addr == 8'hef |=>
        reg_rdata == {1'b0, aux_q[6:0]}) else $error("aux readback wrong");
    rate_out_a: assert property (timer3_rate_select == aux_q[6:3])
        else $error("rate select wrong");
    rdata_idle_a: assert property (!(reg_rd && (reg_addr == 8'hef || reg_addr == 8'hf6))
        |=> reg_rdata == 8'h00) else $error("read data not idle");
endmodule : rchop_ctrl_chk
bind rchop_ctrl rchop_ctrl_chk chk_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_trim_value(osc_trim_value), .timer3_rate_select(timer3_rate_select));

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
    logic       mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [6:0] osc_trim_value;
    logic [3:0] timer3_rate_select;
    int         fail_count = 0, n_tests = 0;
    // rows: address, write data, expected read data
    logic [23:0] rows [6] = '{24'hf60000, 24'hf67f7f, 24'hf62a2a, 24'heff878,
                              24'hef0000, 24'h105500};
    int offs [2][9] = '{'{0, 1, 2, 3, 0, -1, -2, -3, 0}, '{0, 2, 4, 6, 0, -2, -4, -6, 0}};
    always #2.5 mclk = ~mclk;
    rchop_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .osc_trim_value(osc_trim_value), .timer3_rate_select(timer3_rate_select));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task results;
        $display("tests %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // reset, register table rows, both hop patterns, then a reset in mid-hop
    initial begin
        int e;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk({1'b0, osc_trim_value}, 8'h40);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
            if (rows[i][23:16] == 8'hf6) chk({1'b0, osc_trim_value}, rows[i][15:8]);
            if (rows[i][23:16] == 8'hef) chk({4'h0, timer3_rate_select}, rows[i][14:11]);
        end
        for (int p = 0; p < 2; p++) begin
            wr(8'hf6, p ? 8'h02 : 8'h7e);
            wr(8'hef, {7'h01, p[0]});
            repeat (1000) @(posedge mclk);
            for (int k = 0; k < 9; k++) begin
                e = (p ? 2 : 126) + offs[p][k];
                e = e < 0 ? 0 : e;
                e = e > 127 ? 127 : e;
                #1 chk({1'b0, osc_trim_value}, e[7:0]);
                repeat (2000) @(posedge mclk);
            end
            wr(8'hef, 8'h00);
            @(posedge mclk);
            #1 chk({1'b0, osc_trim_value}, p ? 8'h02 : 8'h7e);
        end
        // reset in mid-hop returns every register to its reset value
        wr(8'hef, 8'h7b);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        #1 chk({1'b0, osc_trim_value}, 8'h40);
        chk({4'h0, timer3_rate_select}, 8'h00);
        chk(reg_rdata, 8'h00);
        @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'hef, 8'h00);
        rd(8'hf6, 8'h40);
        results();
    end
endmodule : tb
